// [shared/ilo_pkg.sv]
// Constants and carrier types for the indexed literal offset operand decoder
package ilo_pkg;

	localparam int ADDR_W    = 12;
	localparam int MEM_DEPTH = 4096;

	// Register offsets (byte addresses on the plain register port)
	localparam logic [7:0] OFS_ACCUM    = 8'h00;
	localparam logic [7:0] OFS_FRAME    = 8'h04;
	localparam logic [7:0] OFS_BANK     = 8'h08;
	localparam logic [7:0] OFS_FLAGS    = 8'h0c;
	localparam logic [7:0] OFS_MEM_PTR  = 8'h10;
	localparam logic [7:0] OFS_MEM_DATA = 8'h14;
	localparam logic [7:0] OFS_EXEC     = 8'h18;
	localparam logic [7:0] OFS_LAST_EA  = 8'h1c;

	// Reset values
	localparam logic [7:0]        RST_ACCUM   = 8'h00;
	localparam logic [ADDR_W-1:0] RST_FRAME   = 12'h000;
	localparam logic [3:0]        RST_BANK    = 4'h0;
	localparam logic [4:0]        RST_FLAGS   = 5'h00;
	localparam logic [ADDR_W-1:0] RST_MEM_PTR = 12'h000;

	// Flag field positions
	localparam int FLG_C  = 0;
	localparam int FLG_DC = 1;
	localparam int FLG_Z  = 2;
	localparam int FLG_OV = 3;
	localparam int FLG_N  = 4;

	// Last-address readback field positions
	localparam int LAST_IDX_BIT   = 12;
	localparam int LAST_EXT_BIT   = 13;
	localparam int LAST_VALID_BIT = 14;

	// Operand decoding
	localparam logic [7:0] OFFSET_LIMIT   = 8'h5f;
	localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
	localparam logic [7:0] ALL_ONES       = 8'hff;

	// Opcode prefixes
	localparam logic [5:0] OPC_ADD  = 6'b0010_01;
	localparam logic [6:0] OPC_INDEXED_SET_ALL_ONES = 7'b0110_100;
	localparam logic [3:0] OPC_BSF  = 4'b1000;
	localparam logic [3:0] OPC_BIT_FIRST = 4'h7;
	localparam logic [3:0] OPC_BIT_LAST  = 4'hb;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        we;
		logic        re;
	} reg_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              indexed;
		logic              file_op;
	} operand_addr_t;

	typedef struct packed {
		logic [7:0] sum;
		logic [4:0] flags;
	} alu_out_t;

endpackage

// [hdl/operand_addr_gen.sv]
// Effective data address for byte- and bit-oriented opcodes
`timescale 1ns/100ps
`default_nettype none
module operand_addr_gen
	import ilo_pkg::*;
(
	input  wire logic [15:0]       instr,
	input  wire logic              ext_en,
	input  wire logic [ADDR_W-1:0] frame_ptr,
	input  wire logic [3:0]        bank_sel,
	output operand_addr_t          oa
);
	logic [3:0] top;
	logic       acc_sel;
	logic [7:0] f;

	always_comb begin
		top     = instr[15:12];
		acc_sel = instr[8];
		f       = instr[7:0];
		// Byte ops 0001..0110 plus multiply/decrement; bit ops 0111..1011
		oa.file_op = ((top >= 4'h1) && (top <= OPC_BIT_LAST)) ||
			((top == 4'h0) && !instr[11] && (instr[10:9] != 2'b00)); // RL4
		oa.indexed = ext_en && !acc_sel && (f <= OFFSET_LIMIT) && oa.file_op; // RL2 RL3 RL11
		if (oa.indexed) begin
			// Unsigned, wraps in the data space; bank select plays no part
			oa.addr = frame_ptr + {4'h0, f}; // RL10 RL5
		end else if (!acc_sel) begin
			oa.addr = {(f[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK), f}; // RL1
		end else begin
			oa.addr = {bank_sel, f}; // RL1
		end
	end
endmodule
`default_nettype wire

// [hdl/byte_adder.sv]
// Eight-bit adder producing the arithmetic status flags
`timescale 1ns/100ps
`default_nettype none
module byte_adder
	import ilo_pkg::*;
(
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	output alu_out_t        res
);
	logic [8:0] full;
	logic [4:0] low;

	always_comb begin
		full = {1'b0, a} + {1'b0, b};
		low  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		res.sum            = full[7:0];
		res.flags          = 5'h00;
		res.flags[FLG_C]   = full[8];
		res.flags[FLG_DC]  = low[4];
		res.flags[FLG_Z]   = (full[7:0] == 8'h00);
		res.flags[FLG_N]   = full[7];
		res.flags[FLG_OV]  = (a[7] == b[7]) && (full[7] != a[7]);
	end
endmodule
`default_nettype wire

// [hdl/indexed_literal_offset_decode.sv]
// Operand decode and execution slice with indexed literal offset addressing
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// [RL1] Extension off: file operand is access-bank location, or bank-select bank when a=1.
// [RL2] Extension on, a=0, operand up to 5Fh: offset added to frame pointer.
// [RL3] Operands above 5Fh keep ordinary literal addressing even with extension on.
// [RL4] Offset mode applies to every byte- and bit-oriented opcode carrying a.
// [RL5] Frame pointer 00h makes indexed addresses equal the plain access region.
// [RL6] Destination bit: 0 writes accumulator, 1 writes the indexed location.
// [RL7] Indexed add: accumulator plus byte at pointer+offset, updates N OV C DC Z.
// [RL8] Indexed bit set: sets chosen bit, flags untouched, one cycle.
// [RL9] Indexed set-all-ones: writes FFh to pointer+offset, flags untouched.
// [RL10] Address is unsigned pointer plus offset, used directly, no bank select.
// [RL11] Extension enable is a static setting; clear means standard decoding.
module indexed_literal_offset_decode
	import ilo_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              extension_enable_setting,
	input  wire ilo_pkg::reg_req_t req,
	output logic [31:0]            reg_rdata,
	output logic                   indexed_active
);
	import ilo_pkg::*;

	typedef struct packed {
		logic              ext_sync;
		logic              ext_en;
		logic [7:0]        accum;
		logic [ADDR_W-1:0] frame_ptr;
		logic [3:0]        bank_sel;
		logic [4:0]        flags;
		logic [ADDR_W-1:0] mem_ptr;
		logic [ADDR_W-1:0] last_ea;
		logic              last_indexed;
		logic              last_valid;
		logic [31:0]       rdata;
	} state_t;

	state_t r;
	state_t next_r;

	logic [7:0] data_mem [MEM_DEPTH];

	logic              mem_we;
	logic [ADDR_W-1:0] mem_waddr;
	logic [7:0]        mem_wdata;

	logic [15:0]   instr;
	logic          exec;
	operand_addr_t oa;
	alu_out_t      alu;
	logic [7:0]    operand;
	logic [7:0]    bit_mask;
	logic          is_add;
	logic          is_indexed_set_all_ones;
	logic          is_bsf;

	assign instr = req.wdata[15:0];
	assign exec  = req.we && (req.addr == OFS_EXEC);

	operand_addr_gen u_addr (
		.instr     (instr),
		.ext_en    (r.ext_en),
		.frame_ptr (r.frame_ptr),
		.bank_sel  (r.bank_sel),
		.oa        (oa)
	);

	assign operand = data_mem[oa.addr];

	byte_adder u_add (
		.a   (r.accum),
		.b   (operand),
		.res (alu)
	);

	always_comb begin
		is_add   = (instr[15:10] == OPC_ADD);
		is_indexed_set_all_ones  = (instr[15:9] == OPC_INDEXED_SET_ALL_ONES);
		is_bsf   = (instr[15:12] == OPC_BSF);
		bit_mask = 8'h01 << instr[11:9];
	end

	always_comb begin
		next_r    = r;
		mem_we    = 1'b0;
		mem_waddr = r.mem_ptr;
		mem_wdata = req.wdata[7:0];

		// Setting is a static strap; two stages keep a slow pin clean
		next_r.ext_sync = extension_enable_setting;
		next_r.ext_en   = r.ext_sync; // RL11

		next_r.rdata = 32'h0000_0000;
		if (req.re) begin
			unique case (req.addr)
				OFS_ACCUM:    next_r.rdata[7:0] = r.accum;
				OFS_FRAME:    next_r.rdata[ADDR_W-1:0] = r.frame_ptr;
				OFS_BANK:     next_r.rdata[3:0] = r.bank_sel;
				OFS_FLAGS:    next_r.rdata[4:0] = r.flags;
				OFS_MEM_PTR:  next_r.rdata[ADDR_W-1:0] = r.mem_ptr;
				OFS_MEM_DATA: next_r.rdata[7:0] = data_mem[r.mem_ptr];
				OFS_LAST_EA: begin
					next_r.rdata[ADDR_W-1:0]     = r.last_ea;
					next_r.rdata[LAST_IDX_BIT]   = r.last_indexed;
					next_r.rdata[LAST_EXT_BIT]   = r.ext_en;
					next_r.rdata[LAST_VALID_BIT] = r.last_valid;
				end
				default:      next_r.rdata = 32'h0000_0000;
			endcase
		end

		if (req.we) begin
			unique case (req.addr)
				OFS_ACCUM:    next_r.accum = req.wdata[7:0];
				OFS_FRAME:    next_r.frame_ptr = req.wdata[ADDR_W-1:0];
				OFS_BANK:     next_r.bank_sel = req.wdata[3:0];
				OFS_FLAGS:    next_r.flags = req.wdata[4:0];
				OFS_MEM_PTR:  next_r.mem_ptr = req.wdata[ADDR_W-1:0];
				OFS_MEM_DATA: mem_we = 1'b1;
				default:      next_r.accum = r.accum;
			endcase
		end

		// Whole instruction completes in the cycle it is written
		if (exec && oa.file_op) begin
			next_r.last_ea      = oa.addr; // RL4
			next_r.last_indexed = oa.indexed;
			next_r.last_valid   = 1'b1;
			mem_waddr           = oa.addr;
			if (is_add) begin
				next_r.flags = alu.flags; // RL7
				if (instr[9]) begin
					mem_we    = 1'b1; // RL6
					mem_wdata = alu.sum;
				end else begin
					next_r.accum = alu.sum; // RL6
				end
			end else if (is_indexed_set_all_ones) begin
				mem_we    = 1'b1; // RL9
				mem_wdata = ALL_ONES;
			end else if (is_bsf) begin
				mem_we    = 1'b1; // RL8
				mem_wdata = operand | bit_mask;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r              <= '0;
			r.accum        <= RST_ACCUM;
			r.frame_ptr    <= RST_FRAME;
			r.bank_sel     <= RST_BANK;
			r.flags        <= RST_FLAGS;
			r.mem_ptr      <= RST_MEM_PTR;
		end else begin
			r <= next_r;
		end
	end

	// Data memory is not reset: contents are software's business
	always_ff @(posedge clk) begin
		if (mem_we) begin
			data_mem[mem_waddr] <= mem_wdata;
		end
	end

	assign reg_rdata      = r.rdata;
	assign indexed_active = r.last_indexed;

endmodule
`default_nettype wire

// [dv/ilo_asserts.sv]
// Port-level assertions for the indexed operand decoder
`timescale 1ns/100ps
`default_nettype none
module ilo_asserts
	import ilo_pkg::*;
(
	input wire logic              clk,
	input wire logic              resetn,
	input wire logic              extension_enable_setting,
	input wire ilo_pkg::reg_req_t req,
	input wire logic [31:0]       reg_rdata,
	input wire logic              indexed_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic exec_wr = req.we && req.addr == OFS_EXEC;
	wire logic add_op  = exec_wr && req.wdata[15:10] == OPC_ADD;
	wire logic near_op = !req.wdata[8] && req.wdata[7:0] <= OFFSET_LIMIT;
	// Strap goes through two sync flops, so three stable samples are needed
	sequence s_on; extension_enable_setting [*3]; endsequence
	sequence s_off; !extension_enable_setting [*3]; endsequence
	property p_std; s_off ##0 add_op |=> !indexed_active; endproperty
	a_std: assert property (p_std) else $error("indexed with extension off");
	property p_bank; add_op && req.wdata[8] |=> !indexed_active; endproperty
	a_bank: assert property (p_bank) else $error("indexed with bank select");
	property p_above; add_op && req.wdata[7:0] > OFFSET_LIMIT |=> !indexed_active; endproperty
	a_above: assert property (p_above) else $error("indexed above limit");
	property p_idx; s_on ##0 add_op && near_op |=> indexed_active; endproperty
	a_idx: assert property (p_idx) else $error("add not indexed");
	property p_bit; s_on ##0 exec_wr && req.wdata[15:12] == OPC_BSF && near_op |=> indexed_active;
	endproperty
	a_bit: assert property (p_bit) else $error("bit set not indexed");
	property p_indexed_set_all_ones; s_on ##0 exec_wr && req.wdata[15:9] == OPC_INDEXED_SET_ALL_ONES && near_op |=> indexed_active;
	endproperty
	a_indexed_set_all_ones: assert property (p_indexed_set_all_ones) else $error("set all not indexed");
	property p_hold; $changed(indexed_active) |-> $past(exec_wr); endproperty
	a_hold: assert property (p_hold) else $error("indexed flag moved without execute");
	property p_idle; !$past(req.re) |-> reg_rdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data outside read cycle");
	c_idx: cover property (add_op ##1 indexed_active);
	c_off: cover property (s_off ##0 add_op);
	c_bit: cover property (exec_wr && req.wdata[15:12] == OPC_BSF);
endmodule
bind indexed_literal_offset_decode ilo_asserts u_chk (.clk(clk), .resetn(resetn),
	.extension_enable_setting(extension_enable_setting), .req(req), .reg_rdata(reg_rdata),
	.indexed_active(indexed_active));
`default_nettype wire

// [dv/indexed_literal_offset_decode_bench.sv]
// Self-checking bench for the indexed operand decoder
`timescale 1ns/100ps
`default_nettype none
module indexed_literal_offset_decode_bench;
	import ilo_pkg::*;
	logic        clk = 1'h0;
	logic        resetn = 1'h0;
	logic        ext = 1'h1;
	reg_req_t    req = '0;
	logic [31:0] reg_rdata;
	logic        indexed_active;
	int          num_errors = 0;
	int          samples_checked = 0;
	always #5 clk = ~clk;
	indexed_literal_offset_decode dut (.clk(clk), .resetn(resetn),
		.extension_enable_setting(ext), .req(req), .reg_rdata(reg_rdata),
		.indexed_active(indexed_active));
	task automatic conclude;
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.we <= 1'h1;
		@(posedge clk);
		req.we <= 1'h0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] exp);
		@(posedge clk);
		req.addr <= a;
		req.re <= 1'h1;
		@(posedge clk);
		req.re <= 1'h0;
		#1 chk($sformatf("reg %h", a), exp, reg_rdata);
	endtask
	// Top nibble of the readback: bit0 indexed, bit1 extension, bit2 executed
	task automatic ex(logic [15:0] op, logic [11:0] ea, logic [3:0] top);
		wr(OFS_EXEC, {16'h0, op});
		rd(OFS_LAST_EA, {16'h0, top, ea});
		chk("indexed_active", {31'h0, top[0]}, {31'h0, indexed_active});
	endtask
	task automatic t_reset;
		// Data memory has no reset, so its window is skipped
		// Strap is high and synced by now, so the last-address word shows bit 13
		for (int a = 0; a <= 32; a += 4)
			if (a != 20)
				rd(8'(a), (a == 28) ? 32'h2000 : 32'h0);
	endtask
	task automatic t_add;
		wr(OFS_FRAME, 32'ha00);
		wr(OFS_MEM_PTR, 32'ha2c);
		wr(OFS_MEM_DATA, 32'h20);
		wr(OFS_ACCUM, 32'he9);
		ex(16'h242c, 12'ha2c, 4'h7);
		rd(OFS_ACCUM, 32'h09);
		rd(OFS_FLAGS, 32'h01);
		ex(16'h262c, 12'ha2c, 4'h7);
		rd(OFS_MEM_DATA, 32'h29);
		rd(OFS_ACCUM, 32'h09);
		// Sign overflow with half carry, then a zero result with carry out
		wr(OFS_MEM_DATA, 32'h08);
		wr(OFS_ACCUM, 32'h78);
		ex(16'h242c, 12'ha2c, 4'h7);
		rd(OFS_FLAGS, 32'h1a);
		rd(OFS_ACCUM, 32'h80);
		wr(OFS_MEM_DATA, 32'h80);
		ex(16'h242c, 12'ha2c, 4'h7);
		rd(OFS_FLAGS, 32'h0d);
		rd(OFS_ACCUM, 32'h00);
	endtask
	task automatic t_bit;
		wr(OFS_FLAGS, 32'h1f);
		wr(OFS_MEM_PTR, 32'ha0a);
		wr(OFS_MEM_DATA, 32'h55);
		ex(16'h8e0a, 12'ha0a, 4'h7);
		rd(OFS_MEM_DATA, 32'hd5);
		wr(OFS_MEM_PTR, 32'ha2c);
		ex(16'h682c, 12'ha2c, 4'h7);
		rd(OFS_MEM_DATA, 32'hff);
		rd(OFS_FLAGS, 32'h1f);
	endtask
	task automatic t_edge;
		ex(16'h2460, 12'h060, 4'h6);
		wr(OFS_FRAME, 32'hfff);
		ex(16'h245f, 12'h05e, 4'h7);
		wr(OFS_FRAME, 32'h0);
		ex(16'h2410, 12'h010, 4'h7);
		wr(OFS_BANK, 32'h3);
		ex(16'h2510, 12'h310, 4'h6);
	endtask
	task automatic t_off;
		@(posedge clk);
		ext <= 1'h0;
		repeat (3) @(posedge clk);
		ex(16'h2410, 12'h010, 4'h4);
		ex(16'h8e10, 12'h010, 4'h4);
		ex(16'h2490, 12'hf90, 4'h4);
		ex(16'h2510, 12'h310, 4'h4);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		resetn <= 1'h1;
		t_reset;
		t_add;
		t_bit;
		t_edge;
		t_off;
		conclude;
	end
	// About 130 cycles of traffic; this limit leaves a wide margin
	initial begin
		#50000;
		num_errors++;
		conclude;
	end
endmodule
`default_nettype wire
